//--- design/sdc_bank_if.sv
// Interface carrying decoded commands from the top module to the bank trackers.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ns
interface sdc_bank_if;
  import sdc_pkg::*;
  logic step;
  sdc_cmd_t cmd;
  logic [1:0] bank;
  logic ap;
  logic [ROW_W-1:0] row;
  logic bst_hit;
  logic run;
  logic [NUM_BANKS*3-1:0] state_flat;
  modport ctrl (output step, output cmd, output bank, output ap, output row, output bst_hit, output run,
    input state_flat);
  modport bank_side (input step, input cmd, input bank, input ap, input row, input bst_hit, input run,
    output state_flat);
endinterface

//--- design/sdc_bank_track.sv
// One state record per bank, advanced by decoded commands.
// Assumes the controller keeps commands legal for each bank's state.
`timescale 1ns/1ns
module sdc_bank_track #(
  parameter int BANKS = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  sdc_bank_if.bank_side bif
);
  import sdc_pkg::*;

  genvar g;
  generate
    for (g = 0; g < BANKS; g++) begin : g_bank
      sdc_bank_t st;
      logic [CNT_W-1:0] tmr;
      logic [ROW_W-1:0] open_row;
      logic hit;
      logic take_cmd;
      assign hit = (bif.bank == 2'(g));
      // A bursting bank still has its timer running, yet must accept a chained or cutting command.
      assign take_cmd = bif.step && (tmr == '0 || ((st == SDC_BK_READ || st == SDC_BK_WRITE) &&
          bif.cmd != SDC_CMD_ACTIVE && (hit || (bif.cmd == SDC_CMD_PRE && bif.ap))));
      assign bif.state_flat[g*3 +: 3] = st;

      // Each bank advances on a registered command edge or when its timer runs out.
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          st <= SDC_BK_IDLE;
          tmr <= '0;
          open_row <= '0;
        end else if (tmr != '0 && bif.run && !take_cmd) begin
          tmr <= tmr - 1'b1;
          if (tmr == CNT_W'(1)) begin
            case (st)
              SDC_BK_ACTIVATING: st <= SDC_BK_ROW_ACTIVE;
              SDC_BK_READ, SDC_BK_WRITE: st <= SDC_BK_ROW_ACTIVE;
              SDC_BK_READ_AP, SDC_BK_WRITE_AP: begin
                st <= SDC_BK_PRECHARGING;
                tmr <= CNT_W'(TRP_CYC);
              end
              default: st <= SDC_BK_IDLE;
            endcase
          end
        end else if (take_cmd) begin
          if (bif.bst_hit && hit && (st == SDC_BK_READ || st == SDC_BK_WRITE)) begin
            st <= SDC_BK_ROW_ACTIVE;
            tmr <= '0;
          end else begin
            case (bif.cmd)
              SDC_CMD_ACTIVE: if (hit && st == SDC_BK_IDLE) begin
                st <= SDC_BK_ACTIVATING;
                open_row <= bif.row;
                tmr <= CNT_W'(TRCD_CYC);
              end
              SDC_CMD_READ, SDC_CMD_WRITE: if (hit && (st == SDC_BK_ROW_ACTIVE || st == SDC_BK_READ ||
                  st == SDC_BK_WRITE)) begin
                if (bif.cmd == SDC_CMD_READ) begin
                  st <= bif.ap ? SDC_BK_READ_AP : SDC_BK_READ;
                end else begin
                  st <= bif.ap ? SDC_BK_WRITE_AP : SDC_BK_WRITE;
                end
                tmr <= CNT_W'(BURST_LEN);
              end
              SDC_CMD_PRE: if ((bif.ap || hit) && st != SDC_BK_IDLE) begin
                st <= SDC_BK_PRECHARGING;
                tmr <= CNT_W'(TRP_CYC);
              end
              default: ;
            endcase
          end
        end
      end
    end
  endgenerate
endmodule

//--- design/sdc_cmd_core.sv
// Top of the SDRAM command decoder, power state logic and data mask timing.
// Assumes all pins are synchronous to mclk from an external controller; sys_rst
// stands in for power-up since the device has no reset pin.
//
// How it works
// - Decode command from select and strobe lines.
// - Refresh with clock enable low enters self refresh.
// - Mode load stores address lines as operating code.
// - Activate opens given row in given bank.
// - Read or write takes column, bank, autoprecharge flag.
// - Precharge one bank, or all when flag high.
// - Refresh uses internal counter, ignores other inputs.
// - Mask acts at once on writes, one clock later on reads.
// - Enable low twice holds the low power state.
// - Power down on idle nop with enable falling.
// - Self refresh exit needs nops until recovery.
// - Clock suspend resumes one edge after rise.
// - Bank commands act only with enable high twice; bank timers run unless suspended.
// - Precharge to idle bank changes nothing.
// - Bank active after activate delay passes.
// - Bursting bank without autoprecharge accepts read, write, terminate, precharge.
// - Terminate stops latest burst in any bank, unless that burst has autoprecharge.
// - Autoprecharge bank idles after precharge time.
`timescale 1ns/1ns
module sdc_cmd_core #(
  parameter int BANKS = sdc_pkg::NUM_BANKS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [sdc_pkg::ROW_W-1:0] addr,
  input wire logic dqm,
  output logic [sdc_pkg::MODE_W-1:0] mode_reg,
  output logic [sdc_pkg::ROW_W-1:0] refresh_row,
  output logic [sdc_pkg::NUM_BANKS*3-1:0] bank_state,
  output sdc_pkg::sdc_dev_t dev_state,
  output sdc_pkg::sdc_cmd_t last_cmd,
  output logic [1:0] burst_bank,
  output logic [sdc_pkg::COL_W-1:0] burst_col,
  output logic dq_write_en,
  output logic dq_out_en,
  output logic all_idle
);
  import sdc_pkg::*;

  // Two-stage synchronisers on every pin; the first stage feeds only the second.
  logic [ROW_W+8-1:0] pin_s1;
  logic [ROW_W+8-1:0] pin_s2;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm};
      pin_s2 <= pin_s1;
    end
  end

  logic s_cke;
  logic s_cs_n;
  logic s_ras_n;
  logic s_cas_n;
  logic s_we_n;
  logic [1:0] s_ba;
  logic [ROW_W-1:0] s_addr;
  logic s_dqm;
  assign {s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_ba, s_addr, s_dqm} = pin_s2;

  // Clock enable seen at the previous edge.
  logic cke_prev;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cke_prev <= 1'b0;
    end else begin
      cke_prev <= s_cke;
    end
  end

  // Command decode from the four strobe lines.
  sdc_cmd_t cmd;
  always_comb begin
    if (s_cs_n) begin
      cmd = SDC_CMD_INHIBIT;
    end else begin
      case ({s_ras_n, s_cas_n, s_we_n})
        3'b111: cmd = SDC_CMD_NOP;
        3'b011: cmd = SDC_CMD_ACTIVE;
        3'b101: cmd = SDC_CMD_READ;
        3'b100: cmd = SDC_CMD_WRITE;
        3'b110: cmd = SDC_CMD_BST;
        3'b010: cmd = SDC_CMD_PRE;
        3'b001: cmd = SDC_CMD_REF;
        default: cmd = SDC_CMD_LMR;
      endcase
    end
  end

  logic is_nop;
  assign is_nop = (cmd == SDC_CMD_INHIBIT) || (cmd == SDC_CMD_NOP);

  // Idle detection across all bank records.
  sdc_bank_if bif();
  logic idle_now;
  always_comb begin
    idle_now = 1'b1;
    for (int i = 0; i < BANKS; i++) begin
      if (bif.state_flat[i*3 +: 3] != SDC_BK_IDLE) begin
        idle_now = 1'b0;
      end
    end
  end

  logic bursting;
  always_comb begin
    bursting = 1'b0;
    for (int i = 0; i < BANKS; i++) begin
      if (bif.state_flat[i*3 +: 3] inside {SDC_BK_READ, SDC_BK_WRITE, SDC_BK_READ_AP, SDC_BK_WRITE_AP}) begin
        bursting = 1'b1;
      end
    end
  end

  // Device-wide power and busy state machine.
  sdc_dev_t dev;
  sdc_dev_t next_dev;
  logic [CNT_W-1:0] dev_tmr;
  logic [CNT_W-1:0] next_dev_tmr;
  logic [1:0] xsr_nops;
  always_comb begin
    next_dev = dev;
    next_dev_tmr = (dev_tmr != '0) ? dev_tmr - 1'b1 : dev_tmr;
    case (dev)
      SDC_DEV_NORMAL: begin
        if (cke_prev && !s_cke) begin
          if (idle_now && cmd == SDC_CMD_REF) begin
            next_dev = SDC_DEV_SELF_REFRESH;
          end else if (idle_now && is_nop) begin
            next_dev = SDC_DEV_POWER_DOWN;
          end else if (bursting) begin
            next_dev = SDC_DEV_SUSPEND;
          end
        end else if (cke_prev && s_cke) begin
          if (cmd == SDC_CMD_REF && idle_now) begin
            next_dev = SDC_DEV_REFRESHING;
            next_dev_tmr = CNT_W'(TRC_CYC);
          end else if (cmd == SDC_CMD_LMR && idle_now) begin
            next_dev = SDC_DEV_MODE_LOAD;
            next_dev_tmr = CNT_W'(TMRD_CYC);
          end
        end
      end
      // Low at both edges holds the state whatever the command lines show.
      SDC_DEV_POWER_DOWN: if (s_cke && is_nop) next_dev = SDC_DEV_NORMAL;
      SDC_DEV_SUSPEND: if (s_cke) next_dev = SDC_DEV_NORMAL;
      SDC_DEV_SELF_REFRESH: begin
        if (s_cke && is_nop) begin
          next_dev = SDC_DEV_XSR;
          next_dev_tmr = CNT_W'(TXSR_CYC);
        end
      end
      SDC_DEV_XSR: begin
        if (dev_tmr == '0 && xsr_nops >= 2'(MIN_XSR_NOPS)) next_dev = SDC_DEV_NORMAL;
      end
      SDC_DEV_REFRESHING, SDC_DEV_MODE_LOAD: if (dev_tmr <= CNT_W'(1)) next_dev = SDC_DEV_NORMAL;
      default: next_dev = SDC_DEV_NORMAL;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dev <= SDC_DEV_NORMAL;
      dev_tmr <= '0;
    end else begin
      dev <= next_dev;
      dev_tmr <= next_dev_tmr;
    end
  end

  // Count NOP edges during self refresh exit recovery.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      xsr_nops <= '0;
    end else if (dev != SDC_DEV_XSR) begin
      xsr_nops <= '0;
    end else if (is_nop && xsr_nops != 2'b11) begin
      xsr_nops <= xsr_nops + 1'b1;
    end
  end

  // Commands are registered only with enable high twice and no recovery pending.
  logic step;
  assign step = cke_prev && s_cke && (dev == SDC_DEV_NORMAL) && !is_nop;

  // Burst terminate goes to the bank of the most recent read or write.
  logic [1:0] recent_bank;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      recent_bank <= '0;
    end else if (step && (cmd == SDC_CMD_READ || cmd == SDC_CMD_WRITE)) begin
      recent_bank <= s_ba;
    end
  end

  assign bif.step = step;
  assign bif.cmd = cmd;
  assign bif.bank = (cmd == SDC_CMD_BST) ? recent_bank : s_ba;
  assign bif.ap = s_addr[AP_BIT];
  assign bif.row = s_addr;
  assign bif.bst_hit = step && (cmd == SDC_CMD_BST);
  // Bank timers freeze while the clock is suspended, so a burst resumes where it stopped.
  assign bif.run = (dev != SDC_DEV_SUSPEND);

  // The bank trackers treat a terminate through the bank select of the latest burst.
  sdc_bank_track #(.BANKS(BANKS)) u_banks (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .bif(bif)
  );

  // Mode register captures the address lines on a mode load.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= MODE_RESET;
    end else if (step && cmd == SDC_CMD_LMR && idle_now) begin
      mode_reg <= s_addr;
    end
  end

  // Internal refresh row counter; address pins are never read for refresh.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      refresh_row <= '0;
    end else if (step && cmd == SDC_CMD_REF && idle_now) begin
      refresh_row <= refresh_row + 1'b1;
    end
  end

  // Data mask: writes masked in the same cycle, reads go quiet one clock after writes.
  logic [DQM_RD_LAT-1:0] dqm_pipe;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dqm_pipe <= '1;
      dq_write_en <= 1'b0;
      dq_out_en <= 1'b0;
    end else begin
      dqm_pipe <= {dqm_pipe[DQM_RD_LAT-2:0], s_dqm};
      dq_write_en <= !s_dqm;
      dq_out_en <= !dqm_pipe[DQM_RD_LAT-2];
    end
  end

  // Status outputs mirrored from internal state.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bank_state <= '0;
      dev_state <= SDC_DEV_NORMAL;
      last_cmd <= SDC_CMD_INHIBIT;
      burst_bank <= '0;
      burst_col <= '0;
      all_idle <= 1'b1;
    end else begin
      bank_state <= bif.state_flat;
      dev_state <= dev;
      all_idle <= idle_now;
      if (step) begin
        last_cmd <= cmd;
      end
      if (step && (cmd == SDC_CMD_READ || cmd == SDC_CMD_WRITE)) begin
        burst_bank <= s_ba;
        burst_col <= s_addr[COL_W-1:0];
      end
    end
  end
endmodule

//--- design/sdc_pkg.sv
// Package for the SDRAM command and bank state logic.
// Assumes a single clock domain; shared by the top module and its bank tracker.
package sdc_pkg;
  localparam int NUM_BANKS = 4;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int AP_BIT = 10;
  localparam int MODE_W = 12;
  localparam logic [11:0] MODE_RESET = 12'h0000;
  // Timing figures in nanoseconds and derived cycle counts at 50 ns per clock.
  localparam int CLK_NS = 50;
  localparam int TRCD_NS = 20;
  localparam int TRP_NS = 20;
  localparam int TMRD_NS = 14;
  localparam int TRC_NS = 63;
  localparam int TXSR_NS = 70;
  localparam int TRCD_CYC = (TRCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRP_CYC = (TRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMRD_CYC = (TMRD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRC_CYC = (TRC_NS + CLK_NS - 1) / CLK_NS;
  localparam int TXSR_CYC = (TXSR_NS + CLK_NS - 1) / CLK_NS;
  localparam int MIN_XSR_NOPS = 2;
  localparam int DQM_RD_LAT = 2;
  localparam int BURST_LEN = 4;
  localparam int CNT_W = 8;

  typedef enum logic [3:0] {
    SDC_CMD_INHIBIT = 4'h0,
    SDC_CMD_NOP = 4'h1,
    SDC_CMD_ACTIVE = 4'h2,
    SDC_CMD_READ = 4'h3,
    SDC_CMD_WRITE = 4'h4,
    SDC_CMD_BST = 4'h5,
    SDC_CMD_PRE = 4'h6,
    SDC_CMD_REF = 4'h7,
    SDC_CMD_LMR = 4'h8
  } sdc_cmd_t;

  typedef enum logic [2:0] {
    SDC_BK_IDLE = 3'b000,
    SDC_BK_ACTIVATING = 3'b001,
    SDC_BK_ROW_ACTIVE = 3'b010,
    SDC_BK_READ = 3'b011,
    SDC_BK_WRITE = 3'b100,
    SDC_BK_READ_AP = 3'b101,
    SDC_BK_WRITE_AP = 3'b110,
    SDC_BK_PRECHARGING = 3'b111
  } sdc_bank_t;

  typedef enum logic [2:0] {
    SDC_DEV_NORMAL = 3'b000,
    SDC_DEV_POWER_DOWN = 3'b001,
    SDC_DEV_SELF_REFRESH = 3'b010,
    SDC_DEV_SUSPEND = 3'b011,
    SDC_DEV_XSR = 3'b100,
    SDC_DEV_REFRESHING = 3'b101,
    SDC_DEV_MODE_LOAD = 3'b110
  } sdc_dev_t;
endpackage

//--- verification/sdc_cmd_core_properties.sv
// Checker for the command core, watching its pins and outputs only.
// Assumes the two-stage input synchroniser, so pins act three edges later.
`timescale 1ns/1ns
module sdc_cmd_core_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [sdc_pkg::ROW_W-1:0] addr,
  input wire logic dqm,
  input wire logic [sdc_pkg::MODE_W-1:0] mode_reg,
  input wire logic [sdc_pkg::NUM_BANKS*3-1:0] bank_state,
  input wire sdc_pkg::sdc_dev_t dev_state,
  input wire sdc_pkg::sdc_cmd_t last_cmd,
  input wire logic [1:0] burst_bank,
  input wire logic [sdc_pkg::COL_W-1:0] burst_col,
  input wire logic dq_write_en,
  input wire logic dq_out_en,
  input wire logic all_idle
);
  import sdc_pkg::*;
  logic [18:0] p2, p1, p3;
  logic [2:0] w;
  sdc_cmd_t c;
  logic take;
  logic [2:0] bk;
  function automatic sdc_cmd_t dec(input logic [3:0] s);
    if (s[3]) return SDC_CMD_INHIBIT;
    case (s[2:0])
      3'h7: return SDC_CMD_NOP;
      3'h3: return SDC_CMD_ACTIVE;
      3'h5: return SDC_CMD_READ;
      3'h4: return SDC_CMD_WRITE;
      3'h6: return SDC_CMD_BST;
      3'h2: return SDC_CMD_PRE;
      3'h1: return SDC_CMD_REF;
      default: return SDC_CMD_LMR;
    endcase
  endfunction
  // Pin pipeline mirrors the synchroniser; p3 also gives the previous clock enable.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      p1 <= 19'h0_000f;
      p2 <= 19'h0_000f;
      p3 <= 19'h0_000f;
    end else begin
      p1 <= {cke, ba, addr, cs_n, ras_n, cas_n, we_n};
      p2 <= p1;
      p3 <= p2;
    end
  end
  // Warm-up count, so the mask pipeline is compared only once flushed.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      w <= 3'h0;
    end else if (!w[2]) begin
      w <= w + 3'h1;
    end
  end
  assign c = dec(p2[3:0]);
  assign take = dev_state == SDC_DEV_NORMAL && p2[18] && p3[18];
  assign bk = bank_state[3*p2[17:16] +: 3];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence take_s(sdc_cmd_t k);
    take && c == k;
  endsequence
  sequence fall_s;
    p3[18] && !p2[18] && dev_state == SDC_DEV_NORMAL && all_idle;
  endsequence
  act_opens_a: assert property (take_s(SDC_CMD_ACTIVE) ##0 bk == SDC_BK_IDLE |=> last_cmd == SDC_CMD_ACTIVE
    ##1 bank_state[3*$past(p2[17:16], 2) +: 3] == SDC_BK_ACTIVATING) else $error("activate did not open the bank");
  mode_load_a: assert property (take_s(SDC_CMD_LMR) ##0 all_idle |=> mode_reg == p3[15:4])
    else $error("mode load did not store the address");
  burst_start_a: assert property (take_s(SDC_CMD_READ) ##0 bk == SDC_BK_ROW_ACTIVE |=> burst_col == p3[11:4]
    && burst_bank == p3[17:16] ##1 bank_state[3*$past(p2[17:16], 2) +: 3] ==
    ($past(p2[14], 2) ? SDC_BK_READ_AP : SDC_BK_READ)) else $error("read start wrong");
  pre_idle_a: assert property (take_s(SDC_CMD_PRE) ##0 !p2[14] && bk == SDC_BK_IDLE
    |=> ##1 bank_state[3*$past(p2[17:16], 2) +: 3] == SDC_BK_IDLE) else $error("precharge of idle bank changed it");
  pre_all_a: assert property (take_s(SDC_CMD_PRE) ##0 p2[14] |=> ##1 bank_state[2:0] inside {SDC_BK_IDLE,
    SDC_BK_PRECHARGING} && bank_state[11:9] inside {SDC_BK_IDLE, SDC_BK_PRECHARGING})
    else $error("precharge all left a bank open");
  dq_mask_a: assert property (w[2] |-> dq_out_en == $past(dq_write_en))
    else $error("read mask not one clock behind write mask");
  hold_low_a: assert property (!p2[18] && !p3[18] && dev_state inside {SDC_DEV_POWER_DOWN,
    SDC_DEV_SELF_REFRESH, SDC_DEV_SUSPEND} |=> $stable(dev_state)) else $error("low power state left");
  pd_entry_a: assert property (fall_s ##0 c inside {SDC_CMD_NOP, SDC_CMD_INHIBIT}
    |=> ##1 dev_state == SDC_DEV_POWER_DOWN) else $error("power down not entered");
  sr_entry_a: assert property (fall_s ##0 c == SDC_CMD_REF |=> ##1 dev_state == SDC_DEV_SELF_REFRESH)
    else $error("self refresh not entered");
  ap_idle_a: assert property (bank_state[5:3] == SDC_BK_READ_AP |-> ##[1:12] bank_state[5:3] == SDC_BK_IDLE)
    else $error("auto precharge bank did not close");
endmodule
bind sdc_cmd_core sdc_cmd_core_chk chk (.mclk(mclk), .sys_rst(sys_rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
  .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .mode_reg(mode_reg), .bank_state(bank_state),
  .dev_state(dev_state), .last_cmd(last_cmd), .burst_bank(burst_bank), .burst_col(burst_col),
  .dq_write_en(dq_write_en), .dq_out_en(dq_out_en), .all_idle(all_idle));

//--- verification/sdc_ctrl_model.sv
// Controller model: turns a requested command into select and strobe levels.
// Assumes the bench changes its request on the falling clock edge only.
`timescale 1ns/1ns
module sdc_ctrl_model (
  input wire sdc_pkg::sdc_cmd_t req,
  output logic [3:0] pins
);
  import sdc_pkg::*;
  // Strobe order is select, row, column, write; unknown requests fall back to inhibit.
  always_comb begin
    case (req)
      SDC_CMD_NOP: pins = 4'h7;
      SDC_CMD_ACTIVE: pins = 4'h3;
      SDC_CMD_READ: pins = 4'h5;
      SDC_CMD_WRITE: pins = 4'h4;
      SDC_CMD_BST: pins = 4'h6;
      SDC_CMD_PRE: pins = 4'h2;
      SDC_CMD_REF: pins = 4'h1;
      SDC_CMD_LMR: pins = 4'h0;
      default: pins = 4'hf;
    endcase
  end
endmodule

//--- verification/tb_sdram_command_state_logic.sv
// Self-checking bench for the command core, driving pins through the controller model.
// Assumes pins change on the falling edge; results show three rising edges later.
`timescale 1ns/1ns
module tb_sdram_command_state_logic;
  import sdc_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cke = 1'b1;
  logic dqm = 1'b0;
  logic [1:0] ba = 2'h0;
  logic [11:0] addr = 12'h000;
  sdc_cmd_t req = SDC_CMD_NOP;
  logic [3:0] pins;
  logic [11:0] mode_reg, refresh_row, bank_state, old;
  logic [7:0] burst_col;
  logic [1:0] burst_bank;
  sdc_dev_t dev_state;
  sdc_cmd_t last_cmd;
  logic dq_write_en, dq_out_en, all_idle;
  int err_total = 0;
  int samples_checked = 0;
  always #25 mclk = ~mclk;
  sdc_ctrl_model ctl (.req(req), .pins(pins));
  sdc_cmd_core uut (.mclk(mclk), .sys_rst(sys_rst), .cke(cke), .cs_n(pins[3]), .ras_n(pins[2]), .cas_n(pins[1]),
    .we_n(pins[0]), .ba(ba), .addr(addr), .dqm(dqm), .mode_reg(mode_reg), .refresh_row(refresh_row),
    .bank_state(bank_state), .dev_state(dev_state), .last_cmd(last_cmd), .burst_bank(burst_bank),
    .burst_col(burst_col), .dq_write_en(dq_write_en), .dq_out_en(dq_out_en), .all_idle(all_idle));
  // Shared helpers: compare, wait, single-cycle command, bounded idle wait.
  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Released address lines show the inverse, so stale values never look valid.
  task automatic issue(input sdc_cmd_t c, input logic [1:0] b, input logic [11:0] a);
    req = c;
    ba = b;
    addr = a;
    cyc(1);
    req = SDC_CMD_NOP;
    ba = ~b;
    addr = ~a;
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 40 && all_idle !== 1'b1; i++) cyc(1);
    if (i == 40) begin
      chk("idle_wait", 12'h001, 12'h000);
      stop_test();
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic t_mode_refresh;
    issue(SDC_CMD_LMR, 2'h0, 12'h0a5);
    cyc(4);
    chk("mode_reg", 12'h0a5, mode_reg);
    chk("last_cmd", SDC_CMD_LMR, last_cmd);
    old = refresh_row;
    issue(SDC_CMD_REF, 2'h3, 12'hfff);
    cyc(5);
    chk("refresh_moved", 12'h001, refresh_row !== old);
    chk("mode_kept", 12'h0a5, mode_reg);
  endtask
  task automatic t_bank;
    issue(SDC_CMD_ACTIVE, 2'h1, 12'h123);
    cyc(5);
    chk("bank1", SDC_BK_ROW_ACTIVE, bank_state[5:3]);
    chk("bank0", SDC_BK_IDLE, bank_state[2:0]);
    issue(SDC_CMD_PRE, 2'h0, 12'h000);
    cyc(4);
    chk("bank1_kept", SDC_BK_ROW_ACTIVE, bank_state[5:3]);
    issue(SDC_CMD_READ, 2'h1, 12'h43c);
    cyc(3);
    chk("burst_col", 12'h03c, burst_col);
    chk("burst_bank", 12'h001, burst_bank);
    chk("bank1_ap", SDC_BK_READ_AP, bank_state[5:3]);
    cyc(2);
    wait_idle();
    chk("bank1_idle", SDC_BK_IDLE, bank_state[5:3]);
  endtask
  task automatic t_preall;
    issue(SDC_CMD_ACTIVE, 2'h2, 12'h001);
    cyc(1);
    issue(SDC_CMD_ACTIVE, 2'h3, 12'h002);
    cyc(5);
    chk("open_idle", 12'h000, all_idle);
    issue(SDC_CMD_PRE, 2'h0, 12'h400);
    cyc(4);
    wait_idle();
    chk("all_banks", 12'h000, bank_state);
  endtask
  task automatic t_power;
    cke = 1'b0;
    cyc(5);
    chk("pd_entry", SDC_DEV_POWER_DOWN, dev_state);
    issue(SDC_CMD_ACTIVE, 2'h0, 12'h000);
    cyc(3);
    chk("pd_hold", SDC_DEV_POWER_DOWN, dev_state);
    chk("pd_bank0", SDC_BK_IDLE, bank_state[2:0]);
    cke = 1'b1;
    cyc(5);
    chk("pd_exit", SDC_DEV_NORMAL, dev_state);
    req = SDC_CMD_REF;
    cke = 1'b0;
    cyc(1);
    req = SDC_CMD_NOP;
    cyc(4);
    chk("sr_entry", SDC_DEV_SELF_REFRESH, dev_state);
    cke = 1'b1;
    cyc(8);
    chk("sr_exit", SDC_DEV_NORMAL, dev_state);
  endtask
  // Mask on writes acts one clock ahead of the read output enable.
  task automatic t_mask;
    dqm = 1'b1;
    cyc(3);
    chk("wr_mask", 12'h000, dq_write_en);
    chk("rd_still", 12'h001, dq_out_en);
    cyc(1);
    chk("rd_mask", 12'h000, dq_out_en);
    dqm = 1'b0;
  endtask
  task automatic t_suspend;
    issue(SDC_CMD_ACTIVE, 2'h0, 12'h010);
    cyc(4);
    issue(SDC_CMD_WRITE, 2'h0, 12'h010);
    cyc(1);
    cke = 1'b0;
    cyc(4);
    chk("suspend", SDC_DEV_SUSPEND, dev_state);
    cyc(4);
    chk("burst_frozen", SDC_BK_WRITE, bank_state[2:0]);
    cke = 1'b1;
    cyc(4);
    chk("resume", SDC_DEV_NORMAL, dev_state);
    // Terminate names another bank on purpose; it must still stop the burst in bank 0.
    issue(SDC_CMD_WRITE, 2'h0, 12'h010);
    cyc(1);
    issue(SDC_CMD_BST, 2'h2, 12'h000);
    cyc(3);
    chk("bst_stop", SDC_BK_ROW_ACTIVE, bank_state[2:0]);
    chk("bst_last", SDC_CMD_BST, last_cmd);
    issue(SDC_CMD_PRE, 2'h0, 12'h000);
    cyc(4);
    wait_idle();
  endtask
  initial begin
    cyc(2);
    sys_rst = 1'b0;
    cyc(4);
    t_mode_refresh();
    t_bank();
    t_preall();
    t_power();
    t_mask();
    t_suspend();
    stop_test();
  end
endmodule
